// File: vsc_map.svh
`ifndef VSC_MAP_SVH
`define VSC_MAP_SVH
`define VSC_CTRL_ADDR 8'h00
`define VSC_HSCALE_ADDR 8'h04
`define VSC_VSCALE_ADDR 8'h08
`define VSC_OFFSET_ADDR 8'h0C
`define VSC_BYPASS_ADDR 8'h10
`define VSC_KEYU_ADDR 8'h14
`define VSC_KEYV_ADDR 8'h18
`define VSC_STATUS_ADDR 8'h1C
`define VSC_CCS_BIT 0
`define VSC_AFS_BIT 1
`define VSC_HFS_LSB 2
`define VSC_VPS_LSB 5
`define VSC_GTB_BIT 7
`define VSC_FMT_LSB 8
`define VSC_YOC_BIT 10
`define VSC_LO_LSB 0
`define VSC_HI_LSB 16
`define VSC_KLO_LSB 0
`define VSC_KHI_LSB 8
`define VSC_ST_BYP_BIT 16
`define VSC_ST_SCL_BIT 17
`define VSC_CTRL_RST 32'h0000_0000
`define VSC_HSCALE_RST 32'h02D0_02D0
`define VSC_VSCALE_RST 32'h0120_0120
`define VSC_OFFSET_RST 32'h0000_0000
`define VSC_BYPASS_RST 32'h0000_0000
`define VSC_KEY_RST 32'h0000_807F
`define VSC_CNT_W 10
`define VSC_LINE_DEPTH 768
`define VSC_FMT_YUV 2'h1
`define VSC_FMT_MONO 2'h3
`define VSC_SIGN_FLIP 8'h80
`define VSC_COEF_RV 18'sh00058
`define VSC_COEF_GV 18'sh0002D
`define VSC_COEF_GU 18'sh00016
`define VSC_COEF_BU 18'sh0006F
`define VSC_COEF_SHIFT 6
`define VSC_PIX_MAX 18'sh000FF
`define VSC_RATIO_DEN 4'hF
`define VSC_H_THR1 4'hE
`define VSC_H_THR6 4'hB
`define VSC_H_THR3 4'h7
`define VSC_H_THR4 4'h3
`define VSC_V_THR1 4'hD
`define VSC_V_THR2 4'h4
`define VSC_GAMMA_KNOTS {8'hFF, 8'hE9, 8'hD4, 8'hBF, 8'hAA, 8'h97, 8'h84, \
  8'h72, 8'h61, 8'h50, 8'h41, 8'h32, 8'h25, 8'h18, 8'h0E, 8'h05, 8'h00}
`endif

// File: vsc_pkg.sv
`include "vsc_map.svh"
package vsc_pkg;
  typedef enum logic [2:0] {
    VSC_H_BYP, VSC_H_TAP2, VSC_H_TAP3, VSC_H_TAP4, VSC_H_TAP5, VSC_H_TAP9
  } vsc_hresp_t;
  typedef enum logic [1:0] {VSC_V_BYP, VSC_V_AVG2, VSC_V_AVG3} vsc_vresp_t;
  typedef struct packed {
    logic valid;
    logic keep;
    logic gray;
    logic odd;
    logic bank;
    logic [`VSC_CNT_W-1:0] col;
  } vsc_meta_t;
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
  } vsc_yuv_t;
endpackage

// File: vsc_scaler.sv
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "vsc_map.svh"
module vsc_scaler #(
  parameter int unsigned LINE_DEPTH = `VSC_LINE_DEPTH
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // video from the decoder
  input wire logic clock_reference_qualifier_i,
  input wire logic horizontal_reference_i,
  input wire logic vertical_sync_input_i,
  input wire logic [7:0] luma_input_bus_i,
  input wire logic [7:0] chroma_input_bus_i,
  // processed pixel stream
  output logic pix_valid_o,
  output logic [23:0] pix_data_o,
  output logic pix_key_o,
  output logic pix_gray_o
);
  localparam int unsigned CW = `VSC_CNT_W;
  localparam int unsigned RW = CW + 4;
  localparam logic [135:0] GAMMA = `VSC_GAMMA_KNOTS;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  logic [31:0] ctrl, hscale, vscale, offs, bypass, keyu, keyv;
  logic [CW-1:0] xs, xd, ys, yd, xo, yo, bp_start, bp_count;
  logic ccs, adaptive_filter_select, gtb, yoc;
  logic [2:0] hfs;
  logic [1:0] vps, fmt;
  logic signed [7:0] ulo, uhi, vlo, vhi;
  assign ccs = ctrl[`VSC_CCS_BIT];
  assign adaptive_filter_select = ctrl[`VSC_AFS_BIT];
  assign hfs = ctrl[`VSC_HFS_LSB +: 3];
  assign vps = ctrl[`VSC_VPS_LSB +: 2];
  assign gtb = ctrl[`VSC_GTB_BIT];
  assign fmt = ctrl[`VSC_FMT_LSB +: 2];
  assign yoc = ctrl[`VSC_YOC_BIT];
  assign xs = hscale[`VSC_LO_LSB +: CW];
  assign xd = hscale[`VSC_HI_LSB +: CW];
  assign ys = vscale[`VSC_LO_LSB +: CW];
  assign yd = vscale[`VSC_HI_LSB +: CW];
  assign xo = offs[`VSC_LO_LSB +: CW];
  assign yo = offs[`VSC_HI_LSB +: CW];
  assign bp_start = bypass[`VSC_LO_LSB +: CW];
  assign bp_count = bypass[`VSC_HI_LSB +: CW];
  assign ulo = keyu[`VSC_KLO_LSB +: 8];
  assign uhi = keyu[`VSC_KHI_LSB +: 8];
  assign vlo = keyv[`VSC_KLO_LSB +: 8];
  assign vhi = keyv[`VSC_KHI_LSB +: 8];

  // apb: zero wait states, read data captured in the setup cycle
  logic apb_setup, apb_wr, rd_err;
  logic [31:0] rd_val;
  logic [CW-1:0] line_cnt;
  logic in_scale, in_bypass;
  assign apb_setup = psel_i & ~penable_i;
  assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ctrl <= `VSC_CTRL_RST;
      hscale <= `VSC_HSCALE_RST;
      vscale <= `VSC_VSCALE_RST;
      offs <= `VSC_OFFSET_RST;
      bypass <= `VSC_BYPASS_RST;
      keyu <= `VSC_KEY_RST;
      keyv <= `VSC_KEY_RST;
    end else if (apb_wr) begin
      case (paddr_i)
        `VSC_CTRL_ADDR: ctrl <= pwdata_i;
        `VSC_HSCALE_ADDR: hscale <= pwdata_i;
        `VSC_VSCALE_ADDR: vscale <= pwdata_i;
        `VSC_OFFSET_ADDR: offs <= pwdata_i;
        `VSC_BYPASS_ADDR: bypass <= pwdata_i;
        `VSC_KEYU_ADDR: keyu <= pwdata_i;
        `VSC_KEYV_ADDR: keyv <= pwdata_i;
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    case (paddr_i)
      `VSC_CTRL_ADDR: rd_val = ctrl;
      `VSC_HSCALE_ADDR: rd_val = hscale;
      `VSC_VSCALE_ADDR: rd_val = vscale;
      `VSC_OFFSET_ADDR: rd_val = offs;
      `VSC_BYPASS_ADDR: rd_val = bypass;
      `VSC_KEYU_ADDR: rd_val = keyu;
      `VSC_KEYV_ADDR: rd_val = keyv;
      `VSC_STATUS_ADDR: begin
        rd_val[`VSC_LO_LSB +: CW] = line_cnt;
        rd_val[`VSC_ST_BYP_BIT] = in_bypass;
        rd_val[`VSC_ST_SCL_BIT] = in_scale;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_setup;
      if (apb_setup) begin
        prdata_o <= rd_val;
        pslverr_o <= rd_err;
      end
    end
  end

  apb_ready_a: assert property (apb_setup |=> pready_o ##1 !pready_o)
    else $error("apb slave did not answer in one cycle");

  // video timing: inputs already synchronous to mclk
  logic horizontal_reference_q, vs_q, horizontal_reference_rise, horizontal_reference_fall, vs_rise, slot;
  logic [CW-1:0] col;
  assign horizontal_reference_rise = horizontal_reference_i & ~horizontal_reference_q;
  assign horizontal_reference_fall = horizontal_reference_q & ~horizontal_reference_i;
  assign vs_rise = vertical_sync_input_i & ~vs_q;
  assign slot = clock_reference_qualifier_i & horizontal_reference_i &
                ~vertical_sync_input_i;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      horizontal_reference_q <= 1'b0;
      vs_q <= 1'b0;
    end else begin
      horizontal_reference_q <= horizontal_reference_i;
      vs_q <= vertical_sync_input_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || vs_rise) begin
      line_cnt <= '0;
    end else if (horizontal_reference_fall) begin
      line_cnt <= line_cnt + 1'b1;
    end
  end

  // a short line just stops capture when horizontal_reference drops
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !horizontal_reference_i) begin
      col <= '0;
    end else if (slot && col != '1) begin
      col <= col + 1'b1;
    end
  end

  vsync_reset_a: assert property (vs_rise |=> line_cnt == '0)
    else $error("line counter not cleared by vertical sync");

  // regions from the line and column counters
  logic scale_hit, win;
  assign scale_hit = line_cnt >= yo && (line_cnt - yo) < ys;
  assign in_scale = scale_hit;
  assign in_bypass = !scale_hit && line_cnt >= bp_start &&
                     (line_cnt - bp_start) < bp_count;
  assign win = col >= xo && (col - xo) < xs;

  // line and pixel dropping by running accumulators
  logic [CW:0] v_acc, h_acc, v_sum, h_sum, h_base;
  logic line_keep, h_keep, line_keep_now;
  assign v_sum = v_acc + {1'b0, yd};
  // first slot may share its edge with the horizontal_reference rise: no stale decision
  assign h_base = horizontal_reference_rise ? '0 : h_acc;
  assign h_sum = h_base + {1'b0, xd};
  assign line_keep_now = (horizontal_reference_rise && in_scale) ? v_sum >= {1'b0, ys}
                                                 : line_keep;
  assign h_keep = h_sum >= {1'b0, xs};

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || vs_rise) begin
      v_acc <= '0;
      line_keep <= 1'b0;
    end else if (horizontal_reference_rise && in_scale) begin
      line_keep <= v_sum >= {1'b0, ys};
      v_acc <= (v_sum >= {1'b0, ys}) ? v_sum - {1'b0, ys} : v_sum;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      h_acc <= '0;
    end else if (slot && win) begin
      h_acc <= h_keep ? h_sum - {1'b0, xs} : h_sum;
    end else if (horizontal_reference_rise) begin
      h_acc <= '0;
    end
  end

  // filter selection, adaptive from the ratios or direct
  function automatic vsc_pkg::vsc_hresp_t hmap(input logic [2:0] c);
    case (c)
      3'h0: hmap = vsc_pkg::VSC_H_BYP;
      3'h1: hmap = vsc_pkg::VSC_H_TAP2;
      3'h2, 3'h6: hmap = vsc_pkg::VSC_H_TAP3;
      3'h3: hmap = vsc_pkg::VSC_H_TAP4;
      3'h4: hmap = vsc_pkg::VSC_H_TAP5;
      default: hmap = vsc_pkg::VSC_H_TAP9;
    endcase
  endfunction

  vsc_pkg::vsc_hresp_t hsel;
  vsc_pkg::vsc_vresp_t vsel;
  logic [RW-1:0] xd15, yd15;
  logic [2:0] hcode;
  always_comb begin
    xd15 = RW'(xd) * RW'(`VSC_RATIO_DEN);
    yd15 = RW'(yd) * RW'(`VSC_RATIO_DEN);
    if (xd15 > RW'(xs) * RW'(`VSC_H_THR1)) hcode = 3'h0;
    else if (xd15 > RW'(xs) * RW'(`VSC_H_THR6)) hcode = 3'h1;
    else if (xd15 > RW'(xs) * RW'(`VSC_H_THR3)) hcode = 3'h6;
    else if (xd15 > RW'(xs) * RW'(`VSC_H_THR4)) hcode = 3'h3;
    else hcode = 3'h4;
    hsel = hmap(adaptive_filter_select ? hcode : hfs);
    if (adaptive_filter_select) begin
      if (yd15 > RW'(ys) * RW'(`VSC_V_THR1)) vsel = vsc_pkg::VSC_V_BYP;
      else if (yd15 > RW'(ys) * RW'(`VSC_V_THR2)) vsel = vsc_pkg::VSC_V_AVG2;
      else vsel = vsc_pkg::VSC_V_AVG3;
    end else begin
      case (vps)
        2'h0: vsel = vsc_pkg::VSC_V_BYP;
        2'h1: vsel = vsc_pkg::VSC_V_AVG2;
        default: vsel = vsc_pkg::VSC_V_AVG3;
      endcase
    end
  end

  adaptive_unity_a: assert property (adaptive_filter_select && xd == xs && xs != '0 |->
    hsel == vsc_pkg::VSC_H_BYP)
    else $error("unity ratio did not bypass the horizontal filter");

  // capture: luma taps and stride-two chroma taps
  logic [7:0] y_sr [9];
  logic [7:0] c_sr [17];
  logic [8:0][7:0] y_tap, c_tap;
  logic [7:0] c_in;
  assign c_in = ccs ? chroma_input_bus_i
                    : chroma_input_bus_i ^ `VSC_SIGN_FLIP;

  genvar gi;
  generate
    for (gi = 0; gi < 17; gi++) begin : g_sr
      always_ff @(posedge mclk_i) begin
        if (slot) begin
          c_sr[gi] <= (gi == 0) ? c_in : c_sr[(gi == 0) ? 0 : gi - 1];
        end
      end
      if (gi < 9) begin : g_y
        always_ff @(posedge mclk_i) begin
          if (slot) begin
            y_sr[gi] <= (gi == 0) ? luma_input_bus_i
                                  : y_sr[(gi == 0) ? 0 : gi - 1];
          end
        end
        assign y_tap[gi] = y_sr[gi];
        assign c_tap[gi] = c_sr[2 * gi]; // same component as the newest
      end
    end
  endgenerate

  chroma_conv_a: assert property (slot |=> c_sr[0] == ($past(ccs) ?
    $past(chroma_input_bus_i) : $past(chroma_input_bus_i) ^ `VSC_SIGN_FLIP))
    else $error("chroma not converted to two's complement");

  // meta pipe travels with the data, one entry per stage
  vsc_pkg::vsc_meta_t mp [5];
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 5; i++) mp[i] <= '0;
    end else begin
      mp[0].valid <= slot && (in_bypass || (in_scale && win));
      mp[0].keep <= in_bypass || (line_keep_now && h_keep);
      mp[0].gray <= in_bypass;
      mp[0].odd <= col[0];
      mp[0].bank <= line_cnt[0];
      mp[0].col <= col;
      for (int i = 1; i < 5; i++) mp[i] <= mp[i-1];
    end
  end

  line_abort_a: assert property (!horizontal_reference_i |=> !mp[0].valid)
    else $error("pixel taken with horizontal_reference low");
  scale_first_a: assert property (mp[0].valid && mp[0].gray |->
    $past(!scale_hit)) else $error("bypass over scaling");

  function automatic logic [11:0] ext(input logic [7:0] s, input logic sg);
    ext = sg ? {{4{s[7]}}, s} : {4'h0, s};
  endfunction

  // sums stay in 12 bits, so the picked slice is exact for signed data
  function automatic logic [7:0] hfilt(input vsc_pkg::vsc_hresp_t r,
      input logic [8:0][7:0] s, input logic sg);
    logic [11:0] t;
    t = '0;
    case (r)
      vsc_pkg::VSC_H_TAP2: begin
        t = ext(s[0], sg) + ext(s[1], sg);
        hfilt = t[8:1];
      end
      vsc_pkg::VSC_H_TAP3: begin
        t = ext(s[0], sg) + (ext(s[1], sg) << 1) + ext(s[2], sg);
        hfilt = t[9:2];
      end
      vsc_pkg::VSC_H_TAP4: begin
        t = ext(s[0], sg) + 12'(ext(s[1], sg) * 3) +
            12'(ext(s[2], sg) * 3) + ext(s[3], sg);
        hfilt = t[10:3];
      end
      vsc_pkg::VSC_H_TAP5: begin
        t = ext(s[0], sg) + (ext(s[1], sg) << 2) + 12'(ext(s[2], sg) * 6) +
            (ext(s[3], sg) << 2) + ext(s[4], sg);
        hfilt = t[11:4];
      end
      vsc_pkg::VSC_H_TAP9: begin
        t = ext(s[0], sg) + ext(s[8], sg);
        for (int i = 1; i < 8; i++) t = t + (ext(s[i], sg) << 1);
        hfilt = t[11:4];
      end
      default: hfilt = s[0];
    endcase
  endfunction

  function automatic logic [7:0] vfilt(input vsc_pkg::vsc_vresp_t r,
      input logic [7:0] c, input logic [7:0] p1, input logic [7:0] p2,
      input logic sg);
    logic [11:0] t;
    t = '0;
    case (r)
      vsc_pkg::VSC_V_AVG2: begin
        t = ext(c, sg) + ext(p1, sg);
        vfilt = t[8:1];
      end
      vsc_pkg::VSC_V_AVG3: begin
        t = ext(c, sg) + (ext(p1, sg) << 1) + ext(p2, sg);
        vfilt = t[9:2];
      end
      default: vfilt = c;
    endcase
  endfunction

  // stage 2: horizontal decimation, bypassed in the gray region
  logic [7:0] s2_y, s2_c;
  always_ff @(posedge mclk_i) begin
    s2_y <= hfilt(mp[0].gray ? vsc_pkg::VSC_H_BYP : hsel, y_tap, 1'b0);
    s2_c <= hfilt(mp[0].gray ? vsc_pkg::VSC_H_BYP : hsel, c_tap, 1'b1);
  end

  // stage 3: two line banks per component, ping-pong by line parity
  logic [7:0] ymem [2][LINE_DEPTH];
  logic [7:0] cmem [2][LINE_DEPTH];
  logic [7:0] s3_y, s3_c;
  logic mem_ok;
  vsc_pkg::vsc_vresp_t vuse;
  assign mem_ok = 32'(mp[1].col) < LINE_DEPTH;
  assign vuse = (mp[1].gray || !mem_ok) ? vsc_pkg::VSC_V_BYP : vsel;

  always_ff @(posedge mclk_i) begin
    if (mp[1].valid && mem_ok) begin
      ymem[mp[1].bank][mp[1].col] <= s2_y;
      cmem[mp[1].bank][mp[1].col] <= s2_c;
    end
  end

  // previous line in the other bank, the one before in this bank
  always_ff @(posedge mclk_i) begin
    s3_y <= vfilt(vuse, s2_y, ymem[~mp[1].bank][mem_ok ? mp[1].col : '0],
                  ymem[mp[1].bank][mem_ok ? mp[1].col : '0], 1'b0);
    s3_c <= vfilt(vuse, s2_c, cmem[~mp[1].bank][mem_ok ? mp[1].col : '0],
                  cmem[mp[1].bank][mem_ok ? mp[1].col : '0], 1'b1);
  end

  // stage 4: chroma to 4:4:4 by holding the last U and V
  vsc_pkg::vsc_yuv_t s4;
  logic [7:0] u_hold, v_hold;
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      u_hold <= '0;
      v_hold <= '0;
    end else if (mp[2].valid) begin
      if (mp[2].odd) v_hold <= s3_c;
      else u_hold <= s3_c;
    end
  end

  always_ff @(posedge mclk_i) begin
    s4.y <= s3_y;
    s4.u <= mp[2].odd ? u_hold : s3_c;
    s4.v <= mp[2].odd ? s3_c : v_hold;
  end

  // stage 5: matrix, clamped to 0..255, and the keyer
  function automatic logic [7:0] clamp8(input logic signed [17:0] x);
    logic signed [17:0] t;
    t = x >>> `VSC_COEF_SHIFT;
    if (t < 0) clamp8 = '0;
    else if (t > `VSC_PIX_MAX) clamp8 = '1;
    else clamp8 = t[7:0];
  endfunction

  logic signed [17:0] y_s, u_s, v_s;
  logic [7:0] s5_r, s5_g, s5_b;
  vsc_pkg::vsc_yuv_t s5;
  logic s5_key;
  assign y_s = $signed({10'h000, s4.y}) <<< `VSC_COEF_SHIFT;
  assign u_s = 18'($signed(s4.u));
  assign v_s = 18'($signed(s4.v));

  always_ff @(posedge mclk_i) begin
    s5_r <= clamp8(y_s + `VSC_COEF_RV * v_s);
    s5_g <= clamp8(y_s - `VSC_COEF_GV * v_s - `VSC_COEF_GU * u_s);
    s5_b <= clamp8(y_s + `VSC_COEF_BU * u_s);
    s5 <= s4;
  end

  // an inverted range can never hold a value, so the key stays off
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s5_key <= 1'b0;
    end else begin
      s5_key <= $signed(s4.u) >= ulo && $signed(s4.u) <= uhi &&
                $signed(s4.v) >= vlo && $signed(s4.v) <= vhi;
    end
  end

  key_off_a: assert property ($past(ulo > uhi || vlo > vhi) |-> !s5_key)
    else $error("key set with an inverted range");

  // inverse gamma: 17 knots, linear between them
  function automatic logic [7:0] gamma(input logic [7:0] x);
    logic [7:0] base, k0, k1;
    logic [11:0] d;
    base = {1'b0, x[7:4], 3'b000};
    k0 = GAMMA[base +: 8];
    k1 = GAMMA[base + 8'h08 +: 8];
    d = 12'(k1 - k0) * 12'(x[3:0]);
    gamma = k0 + d[11:4];
  endfunction

  function automatic logic [7:0] code_uv(input logic [7:0] c, input logic t);
    code_uv = t ? c : c ^ `VSC_SIGN_FLIP;
  endfunction

  // stage 6: format, dropping at the buffer input, output registers
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pix_valid_o <= 1'b0;
      pix_data_o <= '0;
      pix_key_o <= 1'b0;
      pix_gray_o <= 1'b0;
    end else begin
      pix_valid_o <= mp[4].valid && mp[4].keep;
      pix_key_o <= s5_key;
      pix_gray_o <= mp[4].gray;
      if (mp[4].gray) begin
        pix_data_o <= {s5.y, 16'h0000};
      end else begin
        case (fmt)
          `VSC_FMT_YUV: pix_data_o <= {s5.y, code_uv(s5.u, yoc),
                                       code_uv(s5.v, yoc)};
          `VSC_FMT_MONO: pix_data_o <= {s5.y, 16'h0000};
          default: pix_data_o <= gtb ? {s5_r, s5_g, s5_b}
              : {gamma(s5_r), gamma(s5_g), gamma(s5_b)};
        endcase
      end
    end
  end

  gray_out_a: assert property (pix_valid_o && pix_gray_o |->
    pix_data_o[15:0] == 16'h0000 && pix_data_o[23:16] == $past(s5.y))
    else $error("bypass pixel not grayscale");
  yuv_unity_a: assert property (pix_valid_o && !pix_gray_o &&
    $past(fmt) == `VSC_FMT_YUV |-> pix_data_o[23:16] == $past(s5.y))
    else $error("luma not passed with unity gain");
  drop_gate_a: assert property (pix_valid_o |->
    $past(mp[4].valid && mp[4].keep))
    else $error("pixel emitted that was marked dropped");
endmodule // vsc_scaler
`default_nettype wire

// File: vsc_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module vsc_src_model (
  // clock
  input wire logic mclk_i,
  // video towards the scaler
  output logic qual_o,
  output logic horizontal_reference_o,
  output logic vsync_o,
  output logic [7:0] luma_o,
  output logic [7:0] chroma_o
);
  initial begin
    qual_o = 1'b0;
    horizontal_reference_o = 1'b0;
    vsync_o = 1'b0;
    luma_o = 8'h00;
    chroma_o = 8'h00;
  end

  // n stays far below 768 so the line stores never overflow
  task automatic send_line(input int n, input logic [7:0] y,
                           input logic [7:0] u, input logic [7:0] v);
    @(posedge mclk_i);
    horizontal_reference_o <= 1'b1;
    for (int i = 0; i < n; i++) begin
      qual_o <= 1'b1;
      luma_o <= y;
      chroma_o <= i[0] ? v : u;
      @(posedge mclk_i);
      qual_o <= 1'b0;
      @(posedge mclk_i);
    end
    horizontal_reference_o <= 1'b0;
    // released bus shows the inverse, never the stale value
    luma_o <= ~y;
    chroma_o <= ~chroma_o;
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic send_vsync();
    @(posedge mclk_i);
    vsync_o <= 1'b1;
    repeat (8) @(posedge mclk_i);
    vsync_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule // vsc_src_model
`default_nettype wire

// File: vsc_scaler_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "vsc_map.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module vsc_scaler_bench;
  logic mclk_i, reset_n_i, psel_i, penable_i, pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic pready_o, pslverr_o, e, qual, horizontal_reference, vsync;
  logic [7:0] luma, chroma;
  logic pix_valid_o, pix_key_o, pix_gray_o, lkey, lgray;
  logic [23:0] pix_data_o, ldata;
  int pcnt, err_count, cmp_count;

  vsc_src_model src (.mclk_i(mclk_i), .qual_o(qual), .horizontal_reference_o(horizontal_reference),
    .vsync_o(vsync), .luma_o(luma), .chroma_o(chroma));
  vsc_scaler dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .clock_reference_qualifier_i(qual),
    .horizontal_reference_i(horizontal_reference), .vertical_sync_input_i(vsync),
    .luma_input_bus_i(luma), .chroma_input_bus_i(chroma),
    .pix_valid_o(pix_valid_o), .pix_data_o(pix_data_o),
    .pix_key_o(pix_key_o), .pix_gray_o(pix_gray_o));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    if (pix_valid_o === 1'b1) begin
      pcnt <= pcnt + 1;
      ldata <= pix_data_o;
      lkey <= pix_key_o;
      lgray <= pix_gray_o;
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // one line in, then count and check what came out
  task automatic line(input int n, input int ec, input logic [23:0] yuv,
                      input logic [23:0] ed, input logic ek, input logic eg);
    pcnt = 0;
    src.send_line(n, yuv[23:16], yuv[15:8], yuv[7:0]);
    repeat (4) @(posedge mclk_i);
    `CHK(pcnt, ec)
    if (ec > 0) begin
      `CHK(ldata, ed)
      `CHK(lgray, eg)
      if (eg === 1'b0) `CHK(lkey, ek)
    end
  endtask

  task report_and_stop;
    $display("compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    report_and_stop;
  end

  initial begin
    err_count = 0;
    cmp_count = 0;
    pcnt = 0;
    reset_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    repeat (30) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, `VSC_HSCALE_ADDR, 32'h0);
    `CHK(r, `VSC_HSCALE_RST)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({e, r}, 33'h1_0000_0000)
    // yuv out, gamma bypass, binary chroma; 8 of 8, two lines of two
    apb(1'b1, `VSC_CTRL_ADDR, 32'h0000_0180);
    apb(1'b1, `VSC_HSCALE_ADDR, 32'h0008_0008);
    apb(1'b1, `VSC_VSCALE_ADDR, 32'h0002_0002);
    apb(1'b1, `VSC_BYPASS_ADDR, 32'h0001_0002);
    apb(1'b1, `VSC_KEYU_ADDR, 32'h0000_3010);
    apb(1'b1, `VSC_KEYV_ADDR, 32'h0000_2000);
    src.send_vsync();
    line(8, 8, 24'h50A090, 24'h50A090, 1'b1, 1'b0);
    line(12, 8, 24'h50A090, 24'h50A090, 1'b1, 1'b0);
    line(12, 12, 24'h50A090, 24'h500000, 1'b0, 1'b1);
    line(6, 0, 24'h50A090, 24'h0, 1'b0, 1'b0);
    // half width, key limits crossed
    apb(1'b1, `VSC_HSCALE_ADDR, 32'h0004_0008);
    apb(1'b1, `VSC_KEYU_ADDR, 32'h0000_1030);
    src.send_vsync();
    line(8, 4, 24'h50A090, 24'h50A090, 1'b0, 1'b0);
    line(5, 2, 24'h50A090, 24'h50A090, 1'b0, 1'b0);
    // rgb with two's complement zero chroma gives grey
    apb(1'b1, `VSC_CTRL_ADDR, 32'h0000_0081);
    src.send_vsync();
    line(8, 4, 24'h500000, 24'h505050, 1'b0, 1'b0);
    report_and_stop;
  end
endmodule // vsc_scaler_bench
`default_nettype wire
